// ===== rtl/nco_peak_detector_config.sv
// Oscillator word staging, extended fraction, peak detector and sync control registers
`timescale 1ns/1ns
`include "nco_pd_defines.svh"

// How it works
// RULE1: Load bit transfers staged word, then self-clears
// RULE2: Frequency word bytes little-endian at 0x02..0x05
// RULE3: Extended register writable only while key held
// RULE4: Software writes zero key when finished
// RULE5: Extended bits 17:0 are fraction numerator
// RULE6: Extended bits 36:18 are 19-bit denominator
// RULE7: Bit 39 enables extended mode; 38:37 ignored
// RULE8: Start bit begins a measurement run
// RULE9: Mode one counts above, zero counts below
// RULE10: Reset bit clears crossing count, self-clears
// RULE11: Threshold is signed eight-bit two's complement
// RULE12: Window length is 48-bit cycle count
// RULE13: Reaching window count sets done flag
// RULE14: Crossing count is 12-bit read-only, resets zero
// RULE15: Sync enables for divider, buffer, oscillator
// RULE16: Sync output selects phase mark or passthrough
// RULE17: Delay inc/dec steps one cycle, limited eight
// RULE18: Status flag clears on zero, one ignored
// RULE19: Extended writes without key are ignored
// RULE20: Word writes staged until load strobe
module nco_peak_detector_config
   import nco_pd_pkg::*;
(
   input  wire logic                  clock,                      // DAC clock
   input  wire logic                  nrst,                       // Synchronous reset, active low
   input  wire logic                  clk_en,                     // Freezes all state while low
   input  wire logic                  wr_en,                      // Register write strobe
   input  wire logic                  rd_en,                      // Register read strobe
   input  wire nco_pd_pkg::reg_addr_t addr,                       // Register byte address
   input  wire nco_pd_pkg::reg_byte_t wr_data,                    // Write data byte
   input  wire nco_pd_pkg::sample_t   sample,                     // Datapath sample, two's complement
   input  wire logic                  sync_input,                 // External sync pin
   input  wire logic                  osc_zero_phase,             // Oscillator zero-phase mark
   output logic [7:0]                 rd_data,                    // Read data byte
   output logic [31:0]                freq_control_word,          // Active oscillator word
   output logic [17:0]                fraction_numerator,         // Active numerator
   output logic [18:0]                fraction_denominator,       // Active denominator
   output logic                       extended_osc_enable,        // Active extended mode
   output logic                       divider_sync_reset,         // Sync reset pulse to divider
   output logic                       input_buffer_sync_reset,    // Sync reset pulse to input buffer
   output logic                       osc_phase_sync_reset,       // Sync reset pulse to oscillator
   output logic                       sync_output,                // Sync output pin
   output logic signed [4:0]          output_delay_offset         // Output interface delay offset
);

   // Configuration state
   logic [31:0]        fcw_stage_r, fcw_stage_nxt;               // Staged frequency word
   logic [39:0]        ext_stage_r, ext_stage_nxt;               // Staged extended word
   logic [31:0]        fcw_r, fcw_nxt;                           // Active word
   logic [39:0]        ext_r, ext_nxt;                           // Active extended word
   logic [7:0]         key_r, key_nxt;                           // Access key
   logic               pd_mode_r, pd_mode_nxt;                   // Count direction
   logic [7:0]         thresh_r, thresh_nxt;                     // Threshold
   logic [47:0]        win_r, win_nxt;                           // Window length
   logic [11:0]        count_r, count_nxt;                       // Crossing count
   logic [47:0]        cyc_r, cyc_nxt;                           // Window cycle counter
   logic               done_r, done_nxt;                         // Window done flag
   pd_state_t          pd_state_r, pd_state_nxt;                 // Detector state
   logic [6:4]         sync_en_r, sync_en_nxt;                   // Sync reset enables
   logic               sync_sel_r, sync_sel_nxt;                 // Sync output source
   logic signed [4:0]  delay_r, delay_nxt;                       // Output delay offset
   logic [1:0]         sync_pin_r;                               // Pin synchroniser
   logic               sync_prev_r;                              // Previous synchronised sync
   logic [7:0]         rd_nxt;                                   // Read mux
   logic [2:0]         sync_pulse_nxt;                           // Sync reset pulses
   logic               sync_out_nxt;                             // Sync output next
   logic               key_ok;                                   // Extended access granted
   logic               sample_hit;                               // Sample crosses threshold

   // Key gate: only the exact open code grants access
   assign key_ok = (key_r == `KEY_OPEN); // RULE3

   // Signed compare so negative thresholds behave
   assign sample_hit = pd_mode_r ? ($signed(sample) > $signed(thresh_r)) // RULE9 RULE11
                                 : ($signed(sample) < $signed(thresh_r));

   // Register writes, load strobe, self-clearing actions and detector
   always_comb
   begin
      fcw_stage_nxt  = fcw_stage_r;
      ext_stage_nxt  = ext_stage_r;
      fcw_nxt        = fcw_r;
      ext_nxt        = ext_r;
      key_nxt        = key_r;
      pd_mode_nxt    = pd_mode_r;
      thresh_nxt     = thresh_r;
      win_nxt        = win_r;
      count_nxt      = count_r;
      cyc_nxt        = cyc_r;
      done_nxt       = done_r;
      pd_state_nxt   = pd_state_r;
      sync_en_nxt    = sync_en_r;
      sync_sel_nxt   = sync_sel_r;
      delay_nxt      = delay_r;
      // Detector runs first so software writes below can override
      unique case (pd_state_r)
         PD_IDLE:
         begin
            cyc_nxt = cyc_r;
         end
         PD_RUN:
         begin
            if (sample_hit && count_r != 12'hFFF)
            begin
               count_nxt = count_r + 12'h001; // RULE9
            end
            if (cyc_r == win_r)
            begin
               done_nxt     = 1'b1; // RULE13
               pd_state_nxt = PD_IDLE;
            end
            else
            begin
               cyc_nxt = cyc_r + 48'h000000000001; // RULE12
            end
         end
      endcase
      if (wr_en)
      begin
         if (addr >= `FCW_ADDR_LO && addr <= `FCW_ADDR_HI)
         begin
            // Lane index wrapped to two bits, else 0x04/0x05 go negative; staged only
            fcw_stage_nxt[8*2'(addr[1:0] - 2'd2) +: 8] = wr_data; // RULE2 RULE20
         end
         else if (addr >= `EXT_ADDR_LO && addr <= `EXT_ADDR_HI)
         begin
            // Locked writes drop silently to protect the fraction
            if (key_ok) // RULE19
            begin
               ext_stage_nxt[8*(32'(addr) - 32'(`EXT_ADDR_LO)) +: 8] = wr_data; // RULE3
            end
         end
         else if (addr >= `PD_WIN_ADDR_LO && addr <= `PD_WIN_ADDR_HI)
         begin
            win_nxt[8*(32'(addr) - 32'(`PD_WIN_ADDR_LO)) +: 8] = wr_data; // RULE12
         end
         else
         begin
            unique case (addr)
               `DSP_CTRL_ADDR:
               begin
                  // Load strobe is never stored, so it reads back zero
                  if (wr_data[`OSC_LOAD_BIT])
                  begin
                     fcw_nxt = fcw_stage_r; // RULE1 RULE20
                     ext_nxt = ext_stage_r;
                  end
               end
               `PD_CTRL_ADDR:
               begin
                  pd_mode_nxt = wr_data[`PD_MODE_BIT];
                  if (wr_data[`PD_RESET_BIT])
                  begin
                     count_nxt = `COUNT_RESET; // RULE10
                  end
                  if (wr_data[`PD_START_BIT])
                  begin
                     pd_state_nxt = PD_RUN; // RULE8
                     cyc_nxt      = 48'h000000000000;
                  end
               end
               `PD_THRESH_ADDR:
               begin
                  thresh_nxt = wr_data; // RULE11
               end
               `STATUS_ADDR:
               begin
                  // Zero clears, one leaves; a done event this cycle wins
                  if (!wr_data[`STATUS_DONE_BIT] && !(pd_state_r == PD_RUN && cyc_r == win_r))
                  begin
                     done_nxt = 1'b0; // RULE18
                  end
               end
               `SYNC_CTRL_ADDR:
               begin
                  sync_en_nxt  = wr_data[`SYNC_DIV_BIT:`SYNC_OSC_BIT]; // RULE15
                  sync_sel_nxt = wr_data[`SYNC_SEL_BIT]; // RULE16
                  // Step bits act on write of one and are not stored
                  if (wr_data[`SYNC_INC_BIT] && !wr_data[`SYNC_DEC_BIT] && delay_r < `DELAY_LIMIT)
                  begin
                     delay_nxt = delay_r + 5'sd1; // RULE17
                  end
                  else if (wr_data[`SYNC_DEC_BIT] && !wr_data[`SYNC_INC_BIT] && delay_r > -`DELAY_LIMIT)
                  begin
                     delay_nxt = delay_r - 5'sd1; // RULE17
                  end
               end
               `KEY_ADDR:
               begin
                  key_nxt = wr_data; // RULE3 RULE4
               end
               default:
               begin
                  key_nxt = key_r;
               end
            endcase
         end
      end
   end

   // Read mux; unmapped addresses read zero, key is write-only
   always_comb
   begin
      rd_nxt = 8'h00;
      if (rd_en)
      begin
         if (addr >= `FCW_ADDR_LO && addr <= `FCW_ADDR_HI)
         begin
            rd_nxt = fcw_stage_r[8*2'(addr[1:0] - 2'd2) +: 8];
         end
         else if (addr >= `EXT_ADDR_LO && addr <= `EXT_ADDR_HI)
         begin
            rd_nxt = ext_stage_r[8*(32'(addr) - 32'(`EXT_ADDR_LO)) +: 8];
         end
         else if (addr >= `PD_WIN_ADDR_LO && addr <= `PD_WIN_ADDR_HI)
         begin
            rd_nxt = win_r[8*(32'(addr) - 32'(`PD_WIN_ADDR_LO)) +: 8];
         end
         else if (addr == `PD_CTRL_ADDR)
         begin
            rd_nxt = {6'h00, pd_mode_r, 1'b0};
         end
         else if (addr == `PD_THRESH_ADDR)
         begin
            rd_nxt = thresh_r;
         end
         else if (addr == `PD_STAT_ADDR_LO)
         begin
            rd_nxt = count_r[7:0]; // RULE14
         end
         else if (addr == `PD_STAT_ADDR_HI)
         begin
            rd_nxt = {4'h0, count_r[11:8]}; // RULE14
         end
         else if (addr == `SYNC_CTRL_ADDR)
         begin
            rd_nxt = {1'b0, sync_en_r, 1'b0, sync_sel_r, 2'b00};
         end
         else if (addr == `STATUS_ADDR)
         begin
            rd_nxt = {7'h00, done_r};
         end
      end
   end

   // Sync pulses fire on rising edge of the synchronised pin
   always_comb
   begin
      sync_pulse_nxt = sync_en_r & {3{sync_pin_r[1] & ~sync_prev_r}}; // RULE15
      sync_out_nxt   = sync_sel_r ? osc_zero_phase : sync_pin_r[1]; // RULE16
   end

   // State registers; everything holds while the clock enable is low
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         fcw_stage_r             <= `FCW_RESET;
         ext_stage_r             <= `EXT_RESET;
         fcw_r                   <= `FCW_RESET;
         ext_r                   <= `EXT_RESET;
         key_r                   <= `KEY_CLOSED;
         pd_mode_r               <= 1'b0;
         thresh_r                <= `THRESH_RESET;
         win_r                   <= `WIN_RESET;
         count_r                 <= `COUNT_RESET; // RULE14
         cyc_r                   <= 48'h000000000000;
         done_r                  <= 1'b0;
         pd_state_r              <= PD_IDLE;
         sync_en_r               <= 3'h0;
         sync_sel_r              <= 1'b0;
         delay_r                 <= 5'sd0;
         sync_pin_r              <= 2'b00;
         sync_prev_r             <= 1'b0;
         rd_data                 <= 8'h00;
         divider_sync_reset      <= 1'b0;
         input_buffer_sync_reset <= 1'b0;
         osc_phase_sync_reset    <= 1'b0;
         sync_output             <= 1'b0;
      end
      else if (clk_en)
      begin
         fcw_stage_r             <= fcw_stage_nxt;
         ext_stage_r             <= ext_stage_nxt;
         fcw_r                   <= fcw_nxt;
         ext_r                   <= ext_nxt;
         key_r                   <= key_nxt;
         pd_mode_r               <= pd_mode_nxt;
         thresh_r                <= thresh_nxt;
         win_r                   <= win_nxt;
         count_r                 <= count_nxt;
         cyc_r                   <= cyc_nxt;
         done_r                  <= done_nxt;
         pd_state_r              <= pd_state_nxt;
         sync_en_r               <= sync_en_nxt;
         sync_sel_r              <= sync_sel_nxt;
         delay_r                 <= delay_nxt;
         sync_pin_r              <= {sync_pin_r[0], sync_input};
         sync_prev_r             <= sync_pin_r[1];
         rd_data                 <= rd_nxt;
         divider_sync_reset      <= sync_pulse_nxt[2];
         input_buffer_sync_reset <= sync_pulse_nxt[1];
         osc_phase_sync_reset    <= sync_pulse_nxt[0];
         sync_output             <= sync_out_nxt;
      end
   end

   // Active fields split from registered words
   assign freq_control_word    = fcw_r;
   assign fraction_numerator   = ext_r[`NUM_MSB:0]; // RULE5
   assign fraction_denominator = ext_r[`DEN_MSB:`DEN_LSB]; // RULE6
   assign extended_osc_enable  = ext_r[`EXT_EN_BIT]; // RULE7
   assign output_delay_offset  = delay_r;

endmodule : nco_peak_detector_config

// ===== rtl/nco_pd_defines.svh
// Register offsets, field positions, reset values and key codes for the oscillator and peak detector config
`ifndef NCO_PD_DEFINES_SVH
`define NCO_PD_DEFINES_SVH
`define DSP_CTRL_ADDR      11'h001
`define FCW_ADDR_LO        11'h002
`define FCW_ADDR_HI        11'h005
`define PD_CTRL_ADDR       11'h006
`define PD_THRESH_ADDR     11'h007
`define PD_WIN_ADDR_LO     11'h008
`define PD_WIN_ADDR_HI     11'h00D
`define PD_STAT_ADDR_LO    11'h00E
`define PD_STAT_ADDR_HI    11'h00F
`define SYNC_CTRL_ADDR     11'h050
`define STATUS_ADDR        11'h056
`define KEY_ADDR           11'h060
`define EXT_ADDR_LO        11'h06B
`define EXT_ADDR_HI        11'h06F
`define OSC_LOAD_BIT       0
`define PD_RESET_BIT       0
`define PD_MODE_BIT        1
`define PD_START_BIT       2
`define SYNC_DEC_BIT       0
`define SYNC_INC_BIT       1
`define SYNC_SEL_BIT       2
`define SYNC_OSC_BIT       4
`define SYNC_BUF_BIT       5
`define SYNC_DIV_BIT       6
`define STATUS_DONE_BIT    0
`define KEY_OPEN           8'h18
`define KEY_CLOSED         8'h00
`define NUM_MSB            17
`define DEN_LSB            18
`define DEN_MSB            36
`define EXT_EN_BIT         39
`define FCW_RESET          32'h00000000
`define EXT_RESET          40'h0000040000
`define THRESH_RESET       8'h00
`define WIN_RESET          48'h000000000000
`define COUNT_RESET        12'h000
`define DELAY_LIMIT        5'sd8
`endif

// ===== rtl/nco_pd_pkg.sv
// Types shared by the oscillator and peak detector config bank
package nco_pd_pkg;
   typedef logic [10:0] reg_addr_t;
   typedef logic [7:0]  reg_byte_t;
   typedef logic [7:0]  sample_t;
   typedef enum logic [0:0] {PD_IDLE, PD_RUN} pd_state_t;
endpackage : nco_pd_pkg

// ===== dv/nco_pd_asserts.sv
// Port-level assertions for the oscillator and peak detector config bank
`timescale 1ns/1ns
`include "nco_pd_defines.svh"
module nco_pd_asserts
   import nco_pd_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  nrst,
   input wire logic                  clk_en,
   input wire logic                  wr_en,
   input wire logic                  rd_en,
   input wire nco_pd_pkg::reg_addr_t addr,
   input wire nco_pd_pkg::reg_byte_t wr_data,
   input wire logic [7:0]            rd_data,
   input wire logic [31:0]           freq_control_word,
   input wire logic [17:0]           fraction_numerator,
   input wire logic [18:0]           fraction_denominator,
   input wire logic                  extended_osc_enable,
   input wire logic                  divider_sync_reset,
   input wire logic                  input_buffer_sync_reset,
   input wire logic                  osc_phase_sync_reset,
   input wire logic signed [4:0]     output_delay_offset
);
   logic [7:0] sync_cfg_r;   // Mirror of the sync control byte
   logic [7:0] sync_cfg_nxt; // Next mirror value
   // Follow taken writes so pulses can be tied to their enables
   always_comb
   begin
      sync_cfg_nxt = sync_cfg_r;
      if (clk_en && wr_en && addr == `SYNC_CTRL_ADDR)
         sync_cfg_nxt = wr_data;
   end
   // Cleared by reset just like the real register
   always_ff @(posedge clock)
   begin
      sync_cfg_r <= nrst ? sync_cfg_nxt : 8'h00;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // Taken writes that step the output delay up or down
   sequence inc_wr;
      clk_en && wr_en && addr == `SYNC_CTRL_ADDR && wr_data[1:0] == 2'b10;
   endsequence
   sequence dec_wr;
      clk_en && wr_en && addr == `SYNC_CTRL_ADDR && wr_data[1:0] == 2'b01;
   endsequence
   reset_vals_a:
      assert property ($rose(nrst) |-> freq_control_word == 32'h00000000 && fraction_numerator == 18'h00000
         && fraction_denominator == 19'h00001 && !extended_osc_enable && output_delay_offset == 5'sd0)
      else $error("outputs not at reset values");
   load_only_a:
      assert property ($changed({freq_control_word, fraction_numerator, fraction_denominator, extended_osc_enable})
         |-> $past(clk_en && wr_en && addr == `DSP_CTRL_ADDR && wr_data[0]))
      else $error("active oscillator changed without load");
   delay_inc_a:
      assert property (inc_wr ##0 output_delay_offset < 5'sd8
         |=> output_delay_offset == $past(output_delay_offset) + 5'sd1)
      else $error("delay did not step up by one");
   delay_dec_a:
      assert property (dec_wr ##0 output_delay_offset > -5'sd8
         |=> output_delay_offset == $past(output_delay_offset) - 5'sd1)
      else $error("delay did not step down by one");
   delay_limit_a:
      assert property (output_delay_offset <= 5'sd8 && output_delay_offset >= -5'sd8)
      else $error("delay offset beyond eight");
   div_pulse_a:
      assert property (divider_sync_reset |-> $past(sync_cfg_r[`SYNC_DIV_BIT]) ##1 !divider_sync_reset)
      else $error("divider sync pulse wrong");
   buf_pulse_a:
      assert property (input_buffer_sync_reset |-> $past(sync_cfg_r[`SYNC_BUF_BIT]) ##1 !input_buffer_sync_reset)
      else $error("buffer sync pulse wrong");
   osc_pulse_a:
      assert property (osc_phase_sync_reset |-> $past(sync_cfg_r[`SYNC_OSC_BIT]) ##1 !osc_phase_sync_reset)
      else $error("oscillator sync pulse wrong");
   refused_rd_a:
      assert property (clk_en && rd_en && (addr == `KEY_ADDR || addr == 11'h051) |=> rd_data == 8'h00)
      else $error("key or unmapped read not zero");
endmodule : nco_pd_asserts
bind nco_peak_detector_config nco_pd_asserts u_asserts (
   .clock(clock), .nrst(nrst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
   .rd_data(rd_data), .freq_control_word(freq_control_word), .fraction_numerator(fraction_numerator),
   .fraction_denominator(fraction_denominator), .extended_osc_enable(extended_osc_enable),
   .divider_sync_reset(divider_sync_reset), .input_buffer_sync_reset(input_buffer_sync_reset),
   .osc_phase_sync_reset(osc_phase_sync_reset), .output_delay_offset(output_delay_offset)
);

// ===== dv/nco_peak_detector_config_tb.sv
// Self-checking bench for the oscillator and peak detector config bank
`timescale 1ns/1ns
`include "nco_pd_defines.svh"
module nco_peak_detector_config_tb;
   import nco_pd_pkg::*;
   // One table row: address, byte written, byte read back
   typedef struct {reg_addr_t a; reg_byte_t d; reg_byte_t r;} row_t;
   logic              clock, nrst, clk_en, wr_en, rd_en, sync_input, osc_zero_phase;
   reg_addr_t         addr;
   reg_byte_t         wr_data;
   sample_t           sample;
   logic [7:0]        rd_data;
   logic [31:0]       freq_control_word;
   logic [17:0]       fraction_numerator;
   logic [18:0]       fraction_denominator;
   logic              extended_osc_enable, divider_sync_reset, input_buffer_sync_reset;
   logic              osc_phase_sync_reset, sync_output;
   logic signed [4:0] output_delay_offset;
   logic [7:0]        p_div, p_buf, p_osc; // Sync pulse tallies
   int                n_mismatch, total_checks, cyc;
   logic [39:0]       ext = 40'h8512EFCDAB; // Extended word the table writes
   // Unmapped and key reads give zero; the rest read back as written
   row_t rows [15] = '{'{11'h002, 8'h11, 8'h11}, '{11'h003, 8'h22, 8'h22}, '{11'h004, 8'h33, 8'h33},
      '{11'h005, 8'h44, 8'h44}, '{11'h007, 8'hF0, 8'hF0}, '{11'h008, 8'h09, 8'h09}, '{11'h00D, 8'h00, 8'h00},
      '{11'h050, 8'h74, 8'h74}, '{11'h051, 8'hFF, 8'h00}, '{11'h060, 8'h18, 8'h00}, '{11'h06B, 8'hAB, 8'hAB},
      '{11'h06C, 8'hCD, 8'hCD}, '{11'h06D, 8'hEF, 8'hEF}, '{11'h06E, 8'h12, 8'h12}, '{11'h06F, 8'h85, 8'h85}};
   nco_peak_detector_config dut (
      .clock(clock), .nrst(nrst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .sample(sample), .sync_input(sync_input), .osc_zero_phase(osc_zero_phase),
      .rd_data(rd_data), .freq_control_word(freq_control_word), .fraction_numerator(fraction_numerator),
      .fraction_denominator(fraction_denominator), .extended_osc_enable(extended_osc_enable),
      .divider_sync_reset(divider_sync_reset), .input_buffer_sync_reset(input_buffer_sync_reset),
      .osc_phase_sync_reset(osc_phase_sync_reset), .sync_output(sync_output),
      .output_delay_offset(output_delay_offset));
   // Free-running 250 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Hang guard; run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cyc++;
      p_div <= p_div + {7'h00, divider_sync_reset};
      p_buf <= p_buf + {7'h00, input_buffer_sync_reset};
      p_osc <= p_osc + {7'h00, osc_phase_sync_reset};
      if (cyc == 5000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // Counts every compare, reports a mismatch at once
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   // One byte write; strobe drops at the taking edge
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(posedge clock);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clock);
      wr_en   <= 1'b0;
   endtask : wr
   // One byte read; data is registered, so look just after the taking edge
   task automatic rd(input reg_addr_t a, input reg_byte_t e);
      @(posedge clock);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial
   begin
      {nrst, clk_en, wr_en, rd_en, sync_input, osc_zero_phase} = 6'b010000;
      addr = 11'h000;
      wr_data = 8'h00;
      sample = 8'h10;
      {p_div, p_buf, p_osc} = 24'h000000;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].r);
      end
      chk(freq_control_word, 32'h00000000);
      $display("table test done");
      wr(`DSP_CTRL_ADDR, 8'h01);
      #1 chk(freq_control_word, 32'h44332211);
      chk(fraction_numerator, ext[17:0]);
      chk(fraction_denominator, ext[36:18]);
      chk(extended_osc_enable, 1'b1);
      rd(`DSP_CTRL_ADDR, 8'h00);
      // Unused bits of the top byte must not reach the denominator
      wr(`EXT_ADDR_HI, 8'hE5);
      wr(`DSP_CTRL_ADDR, 8'h01);
      #1 chk(fraction_denominator, ext[36:18]);
      wr(`KEY_ADDR, `KEY_CLOSED);
      wr(`EXT_ADDR_LO, 8'h55);
      rd(`EXT_ADDR_LO, 8'hAB);
      wr(`DSP_CTRL_ADDR, 8'h01);
      #1 chk(fraction_numerator, ext[17:0]);
      $display("oscillator test done");
      // Window 9 gives ten sample cycles; 0x10 is above 0xF0 only when signed
      wr(`PD_CTRL_ADDR, 8'h07);
      rd(`STATUS_ADDR, 8'h00);
      repeat (16) @(posedge clock);
      rd(`STATUS_ADDR, 8'h01);
      rd(`PD_STAT_ADDR_LO, 8'h0A);
      wr(`STATUS_ADDR, 8'h01);
      rd(`STATUS_ADDR, 8'h01);
      wr(`STATUS_ADDR, 8'h00);
      rd(`STATUS_ADDR, 8'h00);
      sample <= 8'h80;
      wr(`PD_CTRL_ADDR, 8'h04);
      repeat (16) @(posedge clock);
      rd(`PD_STAT_ADDR_LO, 8'h14);
      wr(`PD_CTRL_ADDR, 8'h01);
      rd(`PD_STAT_ADDR_LO, 8'h00);
      sample <= 8'hF0;
      wr(`PD_CTRL_ADDR, 8'h06);
      repeat (16) @(posedge clock);
      rd(`PD_STAT_ADDR_LO, 8'h00);
      $display("peak detector test done");
      osc_zero_phase <= 1'b1;
      repeat (4) @(posedge clock);
      #1 chk(sync_output, 1'b1);
      osc_zero_phase <= 1'b0;
      sync_input <= 1'b1;
      repeat (8) @(posedge clock);
      #1 chk(sync_output, 1'b0);
      chk({p_div, p_buf, p_osc}, 24'h010101);
      wr(`SYNC_CTRL_ADDR, 8'h00);
      repeat (6) @(posedge clock);
      #1 chk(sync_output, 1'b1);
      sync_input <= 1'b0;
      repeat (6) @(posedge clock);
      sync_input <= 1'b1;
      repeat (6) @(posedge clock);
      #1 chk({p_div, p_buf, p_osc}, 24'h010101);
      $display("sync test done");
      repeat (10) wr(`SYNC_CTRL_ADDR, 8'h02);
      #1 chk({output_delay_offset}, 48'h8);
      repeat (17) wr(`SYNC_CTRL_ADDR, 8'h01);
      #1 chk({output_delay_offset}, 48'h18);
      rd(`SYNC_CTRL_ADDR, 8'h00);
      // Both step bits at once must not move the offset
      wr(`SYNC_CTRL_ADDR, 8'h03);
      #1 chk({output_delay_offset}, 48'h18);
      $display("delay test done");
      // A write taken while the clock enable is low must be lost
      clk_en <= 1'b0;
      wr(`PD_THRESH_ADDR, 8'h5A);
      clk_en <= 1'b1;
      rd(`PD_THRESH_ADDR, 8'hF0);
      // Second reset in mid-run
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      #1 chk(fraction_denominator, 19'h00001);
      rd(`PD_STAT_ADDR_LO, 8'h00);
      rd(`PD_THRESH_ADDR, `THRESH_RESET);
      rd(`FCW_ADDR_LO, 8'h00);
      $display("reset test done");
      report_and_stop();
   end
endmodule : nco_peak_detector_config_tb
